// ---- shared/scg_pkg.sv ----
package scg_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CRYSTAL_FREQUENCY_SELECT = 8'h1F;
    localparam logic [7:0] OFS_SYSTEM_CLOCK_CONFIG = 8'h84;
    localparam logic [7:0] OFS_CLOCK_ROUTE_CONTROL = 8'h85;
    localparam logic [7:0] OFS_MODULE_SWITCH_CONTROL = 8'hFE;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_CRYSTAL_RATE_SELECT = 0;
    localparam int BIT_CONVERTER_POWER_DOWN = 0;
    localparam int BIT_SWITCH_RESERVED = 1;
    localparam int BIT_CRYSTAL_POWER_DOWN = 2;
    localparam int BIT_BROWNOUT_POWER_DOWN = 3;
    localparam int BIT_VOLTAGE_DETECTOR_POWER_DOWN = 4;
    localparam int BIT_TIMER_SOURCE_SELECT = 0;
    localparam int BIT_HALF_RATE_GATE_ENABLE = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_CRYSTAL_RATE_SELECT = 1'b0;
    localparam logic [1:0] RST_DIVIDER_SELECT = 2'h1;
    localparam logic RST_POWER_DOWN = 1'b1;
    localparam logic RST_TIMER_SOURCE_SELECT = 1'b0;
    localparam logic RST_HALF_RATE_GATE_ENABLE = 1'b1;
    localparam logic SWITCH_RESERVED_READ = 1'b1;

    // ----------------------------------------------------------------
    // Divider select codes and rates
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SCG_DIV_12MHZ = 2'b00,
        SCG_DIV_6MHZ = 2'b01,
        SCG_DIV_4MHZ = 2'b10,
        SCG_DIV_RESERVED = 2'b11
    } scg_divsel_type;

    localparam int MULT_FULL_RATE_MHZ = 48;
    localparam int MULT_HALF_RATE_MHZ = 24;
    localparam int HALF_RATE_RATIO = MULT_FULL_RATE_MHZ / MULT_HALF_RATE_MHZ;
    // System clock factors applied to the half-rate clock
    localparam logic [2:0] FACTOR_12MHZ = 3'h2;
    localparam logic [2:0] FACTOR_6MHZ = 3'h4;
    localparam logic [2:0] FACTOR_4MHZ = 3'h6;

    // Number of asynchronous clock pins sampled by this block
    localparam int PIN_COUNT = 3;
    localparam int PIN_LOW_SPEED_RC = 0;
    localparam int PIN_FAST_RC = 1;
    localparam int PIN_CRYSTAL = 2;
endpackage : scg_pkg

// ---- src/scg_clock_control.sv ----
module scg_clock_control
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Clock sources
    input wire logic multiplierFullRateTick,
    input wire logic lowSpeedRcPin,
    input wire logic fastRcPin,
    input wire logic crystalPin,
    // Derived clock enables
    output logic multiplierFullRateClock,
    output logic multiplierHalfRateClock,
    output logic systemClockTick,
    output logic systemClockLevel,
    output logic watchdogClockTick,
    output logic ledClockTick,
    output logic timerClockTick,
    // Analog controls
    output logic crystalRateSelect,
    output logic crystalPowerDown,
    output logic voltageDetectorPowerDown,
    output logic brownoutDetectorPowerDown,
    output logic converterPowerDown
);
    // ----------------------------------------------------------------
    // Clocking scheme
    // ----------------------------------------------------------------
    // Every derived clock but systemClockLevel leaves as a one-cycle enable on mclk, so all
    // consumers share one domain and no gated clock tree is needed.
    // Oscillator pins are sampled, not used as clocks: each source must
    // stay longer than one mclk cycle high and low or edges are lost.
    // The divider reloads its factor only at a period wrap, so a new
    // code shows one more period at the old rate first.

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic crystalRate_r;
    scg_divsel_type dividerSelect_r;
    logic timerSource_r;
    logic halfGateEnable_r;
    logic crystalOff_r;
    logic detectorOff_r;
    logic brownoutOff_r;
    logic converterOff_r;
    logic [7:0] rdData_nxt;

    // Divider and pin synchroniser results
    logic [PIN_COUNT-1:0] pinRise;
    logic halfTick;
    logic sysTick;
    logic sysLevel;
    logic [2:0] factor;
    logic crystalTick;

    // One write strobe per register
    logic wrCrystal;
    logic wrSystem;
    logic wrRoute;
    logic wrSwitch;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Unmapped offsets match none, so their writes are dropped
    assign wrCrystal = regWrite && (regAddr == OFS_CRYSTAL_FREQUENCY_SELECT);
    assign wrSystem = regWrite && (regAddr == OFS_SYSTEM_CLOCK_CONFIG);
    assign wrRoute = regWrite && (regAddr == OFS_CLOCK_ROUTE_CONTROL);
    assign wrSwitch = regWrite && (regAddr == OFS_MODULE_SWITCH_CONTROL);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Crystal rate bit, reset to 32768 Hz
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crystalRate_r <= RST_CRYSTAL_RATE_SELECT;
        end else if (wrCrystal) begin
            crystalRate_r <= regWrData[BIT_CRYSTAL_RATE_SELECT];
        end
    end

    // A rejected code leaves the running rate untouched
    // Divider select; reserved code ignored to keep a legal rate
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dividerSelect_r <= scg_divsel_type'(RST_DIVIDER_SELECT);
        end else if (wrSystem &&
                     (regWrData[1:0] != SCG_DIV_RESERVED)) begin
            dividerSelect_r <= scg_divsel_type'(regWrData[1:0]);
        end
    end

    // Timer source and half-rate gate control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timerSource_r <= RST_TIMER_SOURCE_SELECT;
            halfGateEnable_r <= RST_HALF_RATE_GATE_ENABLE;
        end else if (wrRoute) begin
            timerSource_r <= regWrData[BIT_TIMER_SOURCE_SELECT];
            halfGateEnable_r <= regWrData[BIT_HALF_RATE_GATE_ENABLE];
        end
    end

    // Crystal switch bit, off after reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crystalOff_r <= RST_POWER_DOWN;
        end else if (wrSwitch) begin
            crystalOff_r <= regWrData[BIT_CRYSTAL_POWER_DOWN];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            detectorOff_r <= RST_POWER_DOWN;
            brownoutOff_r <= RST_POWER_DOWN;
            converterOff_r <= RST_POWER_DOWN;
        end else if (wrSwitch) begin
            detectorOff_r <= regWrData[BIT_VOLTAGE_DETECTOR_POWER_DOWN];
            brownoutOff_r <= regWrData[BIT_BROWNOUT_POWER_DOWN];
            converterOff_r <= regWrData[BIT_CONVERTER_POWER_DOWN];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read mux; unmapped and unused bits read as zero, reserved switch bit as one
    always_comb begin
        rdData_nxt = 8'h00;
        unique case (regAddr)
            OFS_CRYSTAL_FREQUENCY_SELECT: begin
                rdData_nxt[BIT_CRYSTAL_RATE_SELECT] = crystalRate_r;
            end
            OFS_SYSTEM_CLOCK_CONFIG: begin
                rdData_nxt[1:0] = dividerSelect_r;
            end
            OFS_CLOCK_ROUTE_CONTROL: begin
                rdData_nxt[BIT_TIMER_SOURCE_SELECT] = timerSource_r;
                rdData_nxt[BIT_HALF_RATE_GATE_ENABLE] = halfGateEnable_r;
            end
            OFS_MODULE_SWITCH_CONTROL: begin
                rdData_nxt[BIT_CONVERTER_POWER_DOWN] = converterOff_r;
                rdData_nxt[BIT_SWITCH_RESERVED] = SWITCH_RESERVED_READ;
                rdData_nxt[BIT_CRYSTAL_POWER_DOWN] = crystalOff_r;
                rdData_nxt[BIT_BROWNOUT_POWER_DOWN] = brownoutOff_r;
                rdData_nxt[BIT_VOLTAGE_DETECTOR_POWER_DOWN] = detectorOff_r;
            end
            default: begin
                rdData_nxt = 8'h00;
            end
        endcase
    end

    // Registered read costs a cycle but keeps decode glitches off the
    // bus; zero outside reads lets a master OR several slaves together
    // Data stand only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRead ? rdData_nxt : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Clock division
    // ----------------------------------------------------------------
    // Default never taken: the write path rejects the reserved code
    // Code to factor of the half-rate clock
    always_comb begin
        unique case (dividerSelect_r)
            SCG_DIV_12MHZ: factor = FACTOR_12MHZ;
            SCG_DIV_6MHZ: factor = FACTOR_6MHZ;
            SCG_DIV_4MHZ: factor = FACTOR_4MHZ;
            default: factor = FACTOR_6MHZ;
        endcase
    end

    // All lower rates come from the full-rate tick
    scg_rate_divider uDivider (
        .mclk(mclk),
        .resetn(resetn),
        .fullTick(multiplierFullRateTick),
        .factor(factor),
        .halfTick(halfTick),
        .sysTick(sysTick),
        .sysLevel(sysLevel)
    );

    // ----------------------------------------------------------------
    // Asynchronous oscillator pins
    // ----------------------------------------------------------------
    // Pins packed in the order of the pin index constants
    scg_pin_sync uPinSync (
        .mclk(mclk),
        .resetn(resetn),
        .pinIn({crystalPin, fastRcPin, lowSpeedRcPin}),
        .pinRise(pinRise)
    );

    // Gated after the synchroniser, so edges already in flight are
    // dropped as soon as the power-down bit is set
    // Crystal edges blocked while the oscillator is off
    assign crystalTick = pinRise[PIN_CRYSTAL] & ~crystalOff_r;

    // ----------------------------------------------------------------
    // Clock routing, registered so outputs come from flip-flops
    // ----------------------------------------------------------------
    // Each enable is re-registered: one cycle later than its source,
    // but every output comes straight from a flip-flop
    // Full-rate clock passed straight to converter and flash
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            multiplierFullRateClock <= 1'b0;
        end else begin
            multiplierFullRateClock <= multiplierFullRateTick;
        end
    end

    // Gated half-rate clock for serial, flash and PWM
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            multiplierHalfRateClock <= 1'b0;
        end else begin
            multiplierHalfRateClock <= halfTick & halfGateEnable_r;
        end
    end

    // Tick and level leave together; the level rises two cycles after its tick
    // System clock enable and level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            systemClockTick <= 1'b0;
            systemClockLevel <= 1'b1;
        end else begin
            systemClockTick <= sysTick;
            systemClockLevel <= sysLevel;
        end
    end

    // Watchdog keeps running whatever the timer source selects
    // Low-speed RC clock drives the watchdog
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            watchdogClockTick <= 1'b0;
        end else begin
            watchdogClockTick <= pinRise[PIN_LOW_SPEED_RC];
        end
    end

    // Fast RC oscillator clocks the LED drive
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ledClockTick <= 1'b0;
        end else begin
            ledClockTick <= pinRise[PIN_FAST_RC];
        end
    end

    // A source switch takes effect at the next edge of the new input
    // Timer picks crystal or low-speed RC
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timerClockTick <= 1'b0;
        end else begin
            timerClockTick <= timerSource_r ? crystalTick :
                              pinRise[PIN_LOW_SPEED_RC];
        end
    end

    // ----------------------------------------------------------------
    // Analog control outputs
    // ----------------------------------------------------------------
    // Levels leave straight from the register flops
    assign crystalRateSelect = crystalRate_r;
    assign crystalPowerDown = crystalOff_r;
    assign voltageDetectorPowerDown = detectorOff_r;
    assign brownoutDetectorPowerDown = brownoutOff_r;
    assign converterPowerDown = converterOff_r;
endmodule : scg_clock_control

// ---- src/scg_pin_sync.sv ----
module scg_pin_sync
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [PIN_COUNT-1:0] pinIn,
    output logic [PIN_COUNT-1:0] pinRise
);
    // ----------------------------------------------------------------
    // Two-stage synchroniser and rising-edge detector per pin
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] stage1_r;
    logic [PIN_COUNT-1:0] stage2_r;
    logic [PIN_COUNT-1:0] stage3_r;

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : gPin
            // Stage one feeds only stage two
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    stage1_r[g] <= 1'b0;
                    stage2_r[g] <= 1'b0;
                    stage3_r[g] <= 1'b0;
                    pinRise[g] <= 1'b0;
                end else begin
                    stage1_r[g] <= pinIn[g];
                    stage2_r[g] <= stage1_r[g];
                    stage3_r[g] <= stage2_r[g];
                    pinRise[g] <= stage2_r[g] & ~stage3_r[g];
                end
            end
        end
    endgenerate
endmodule : scg_pin_sync

// ---- src/scg_rate_divider.sv ----
module scg_rate_divider
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fullTick,
    input wire logic [2:0] factor,
    output logic halfTick,
    output logic sysTick,
    output logic sysLevel
);
    // ----------------------------------------------------------------
    // Half-rate phase from the full-rate tick
    // ----------------------------------------------------------------
    localparam logic [1:0] HALF_LAST = 2'(HALF_RATE_RATIO - 1);
    logic [1:0] halfCount_r;
    logic [2:0] count_r;
    logic [2:0] factor_r;
    logic wrap;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            halfCount_r <= 2'h0;
        end else if (fullTick) begin
            halfCount_r <= (halfCount_r == HALF_LAST) ? 2'h0 :
                           2'(halfCount_r + 2'h1);
        end
    end

    assign halfTick = fullTick && (halfCount_r == HALF_LAST);

    // ----------------------------------------------------------------
    // System period counter
    // ----------------------------------------------------------------
    assign wrap = halfTick && (count_r == 3'(factor_r - 3'h1));

    // Factor loaded only at wrap, so no short pulse
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_r <= 3'h0;
            factor_r <= FACTOR_6MHZ;
        end else if (wrap) begin
            count_r <= 3'h0;
            factor_r <= factor;
        end else if (halfTick) begin
            count_r <= 3'(count_r + 3'h1);
        end
    end

    // High for first half of the selected period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sysLevel <= 1'b1;
        end else begin
            sysLevel <= count_r < (factor_r >> 1);
        end
    end

    assign sysTick = wrap;
endmodule : scg_rate_divider

// ---- tb/scg_clock_control_props.sv ----
module scg_clock_control_props
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic multiplierFullRateTick,
    input wire logic lowSpeedRcPin,
    input wire logic fastRcPin,
    input wire logic multiplierFullRateClock,
    input wire logic multiplierHalfRateClock,
    input wire logic systemClockTick,
    input wire logic watchdogClockTick,
    input wire logic ledClockTick,
    input wire logic timerClockTick,
    input wire logic crystalRateSelect,
    input wire logic crystalPowerDown,
    input wire logic converterPowerDown
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so one clock and reset serve all
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Writes aimed at the switch and crystal registers
    sequence sSwitchWrite;
        regWrite && regAddr == OFS_MODULE_SWITCH_CONTROL;
    endsequence
    sequence sRateWrite;
        regWrite && regAddr == OFS_CRYSTAL_FREQUENCY_SELECT;
    endsequence

    a_read_idle_zero: assert property (
        !$past(regRead) |-> regRdData == 8'h00) else $error("read idle");
    a_full_rate_copy: assert property ($past(resetn) |->
        multiplierFullRateClock == $past(multiplierFullRateTick))
        else $error("full rate copy wrong");
    a_half_rate_gap: assert property (
        multiplierHalfRateClock |=> !multiplierHalfRateClock)
        else $error("half rate pulses adjacent");
    a_system_tick_gap: assert property (
        systemClockTick |=> !systemClockTick [*3])
        else $error("system period too short");
    a_watchdog_edge: assert property (
        $rose(lowSpeedRcPin) |-> ##[3:5] watchdogClockTick)
        else $error("watchdog tick missing");
    a_led_edge: assert property (
        $rose(fastRcPin) |-> ##[3:5] ledClockTick)
        else $error("led tick missing");
    a_timer_crystal_off: assert property (crystalPowerDown &&
        $past(crystalPowerDown, 5) && timerClockTick |-> watchdogClockTick)
        else $error("crystal tick while off");
    a_crystal_power_write: assert property (sSwitchWrite |=>
        crystalPowerDown == $past(regWrData[BIT_CRYSTAL_POWER_DOWN]))
        else $error("crystal power bit wrong");
    a_converter_write: assert property (sSwitchWrite |=>
        converterPowerDown == $past(regWrData[BIT_CONVERTER_POWER_DOWN]))
        else $error("converter bit wrong");
    a_rate_write: assert property (sRateWrite |=>
        crystalRateSelect == $past(regWrData[BIT_CRYSTAL_RATE_SELECT]))
        else $error("crystal rate bit wrong");
    a_rate_hold: assert property (
        !$past(regWrite) |-> $stable(crystalRateSelect))
        else $error("crystal rate moved");
endmodule : scg_clock_control_props

bind scg_clock_control scg_clock_control_props i_props (
    .mclk, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .multiplierFullRateTick, .lowSpeedRcPin, .fastRcPin,
    .multiplierFullRateClock, .multiplierHalfRateClock, .systemClockTick,
    .watchdogClockTick, .ledClockTick, .timerClockTick,
    .crystalRateSelect, .crystalPowerDown, .converterPowerDown
);

// ---- tb/scg_clock_control_test.sv ----
module scg_clock_control_test
    import scg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, regWrite, regRead, multiplierFullRateTick, tickOn;
    logic lowSpeedRcPin, fastRcPin, crystalPin;
    logic [7:0] regAddr, regWrData, regRdData, a;
    logic multiplierFullRateClock, multiplierHalfRateClock, systemClockTick;
    logic systemClockLevel, watchdogClockTick, ledClockTick, timerClockTick;
    logic crystalRateSelect, crystalPowerDown, voltageDetectorPowerDown;
    logic brownoutDetectorPowerDown, converterPowerDown;
    logic [16:0] lfsr_r;
    logic [7:0] expReg [256];
    logic [7:0] addrs [5] = '{8'h1F, 8'h84, 8'h85, 8'hFE, 8'h40};
    int failures, checks_done, cycles, pinCnt, f, h;
    int cFull, cHalf, cWd, cLed, cTim, cLvl, v, dW, dL, dT;

    scg_clock_control i_dut (
        .mclk, .resetn, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .multiplierFullRateTick, .lowSpeedRcPin, .fastRcPin,
        .crystalPin, .multiplierFullRateClock, .multiplierHalfRateClock,
        .systemClockTick, .systemClockLevel, .watchdogClockTick,
        .ledClockTick, .timerClockTick, .crystalRateSelect,
        .crystalPowerDown, .voltageDetectorPowerDown,
        .brownoutDetectorPowerDown, .converterPowerDown
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Sources at distinct rates; pins rest low in reset
    always @(posedge mclk) begin
        pinCnt <= pinCnt + 1;
        cycles <= cycles + 1;
        multiplierFullRateTick <= tickOn & ~multiplierFullRateTick;
        lowSpeedRcPin <= resetn & (pinCnt % 16 < 8);
        fastRcPin <= resetn & (pinCnt % 10 < 5);
        crystalPin <= resetn & (pinCnt % 6 < 3);
        cFull <= cFull + multiplierFullRateClock;
        cHalf <= cHalf + multiplierHalfRateClock;
        cWd <= cWd + watchdogClockTick;
        cLed <= cLed + ledClockTick;
        cTim <= cTim + timerClockTick;
        cLvl <= cLvl + systemClockLevel;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    function automatic logic [16:0] lfsr_next(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr_next

    // Register image after a write; code 11 leaves the divider alone
    function automatic logic [7:0] wr_model(logic [7:0] ad, d, old);
        case (ad)
            OFS_CRYSTAL_FREQUENCY_SELECT: return {7'h00, d[0]};
            OFS_SYSTEM_CLOCK_CONFIG: return d[1:0] == 2'h3 ? old : d & 8'h03;
            OFS_CLOCK_ROUTE_CONTROL: return d & 8'h03;
            OFS_MODULE_SWITCH_CONTROL: return (d & 8'h1D) | 8'h02;
            default: return old;
        endcase
    endfunction : wr_model

    function automatic int near(int d, int e);
        return (d >= e - 1 && d <= e + 1) ? 1 : 0;
    endfunction : near

    task automatic check(logic [7:0] seen, exp, string m);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s %h not %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic reg_write(logic [7:0] ad, d);
        regAddr <= ad;
        regWrData <= d;
        regWrite <= 1'b1;
        expReg[ad] = wr_model(ad, d, expReg[ad]);
        @(posedge mclk);
        regWrite <= 1'b0;
        // Idle edge so back-to-back writes never reassign the strobe
        @(posedge mclk);
    endtask : reg_write

    task automatic reg_read(logic [7:0] ad);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        check(regRdData, expReg[ad], "read");
        @(posedge mclk);
    endtask : reg_read

    // Levels to the analog side follow the register image
    task automatic check_outs();
        check({3'h0, crystalRateSelect, crystalPowerDown,
            voltageDetectorPowerDown, brownoutDetectorPowerDown,
            converterPowerDown}, {3'h0, expReg[8'h1F][0], expReg[8'hFE][2],
            expReg[8'hFE][4], expReg[8'hFE][3], expReg[8'hFE][0]}, "levels");
    endtask : check_outs

    task automatic reset_dut();
        resetn <= 1'b0;
        foreach (expReg[i]) expReg[i] = 8'h00;
        expReg[8'h84] = 8'h01;
        expReg[8'h85] = 8'h02;
        expReg[8'hFE] = 8'h1F;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        foreach (addrs[i]) reg_read(addrs[i]);
        check_outs();
        $display("test reset done");
    endtask : reset_dut

    task automatic wait_sys();
        int n;
        n = 0;
        @(posedge mclk);
        while (systemClockTick !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        if (n == 300) failures++;
    endtask : wait_sys

    task automatic window(int n);
        int w, l, t;
        w = cWd;
        l = cLed;
        t = cTim;
        repeat (n) @(posedge mclk);
        dW = cWd - w;
        dL = cLed - l;
        dT = cTim - t;
    endtask : window

    initial begin
        {regWrite, regRead, regAddr, regWrData, tickOn} = '0;
        {multiplierFullRateTick, lowSpeedRcPin, fastRcPin, crystalPin} = '0;
        {failures, checks_done, cycles, pinCnt} = '0;
        {cFull, cHalf, cWd, cLed, cTim, cLvl} = '0;
        resetn = 1'b0;
        lfsr_r = 17'h109C6;
        tickOn <= 1'b1;
        reset_dut();
        // Random writes, each read back at once
        repeat (30) begin
            lfsr_r = lfsr_next(lfsr_r);
            a = lfsr_r[3] ? addrs[lfsr_r[2:0] % 5] : lfsr_r[16:9];
            reg_write(a, lfsr_r[7:0]);
            reg_read(a);
            check_outs();
        end
        $display("test registers done");
        reg_write(8'h85, 8'h02);
        // Each code, the reserved one last; the two periods after the first are averaged
        for (int c = 0; c < 4; c++) begin
            reg_write(8'h84, 8'(c));
            wait_sys();
            f = cFull;
            h = cHalf;
            v = cLvl;
            wait_sys();
            wait_sys();
            h = (cHalf - h) / 2;
            f = (cFull - f) / 2;
            v = (cLvl - v) / 2;
            check(8'(f), 8'(4 + 4 * expReg[8'h84][1:0]), "full");
            check(8'(h), 8'(2 + 2 * expReg[8'h84][1:0]), "half");
            // Level high half the period: one mclk per full-rate tick
            check(8'(v), 8'(4 + 4 * expReg[8'h84][1:0]), "level");
        end
        reg_write(8'h85, 8'h00);
        // Let the last pulse launched before the gate closed be counted
        @(posedge mclk);
        h = cHalf;
        repeat (60) @(posedge mclk);
        check(8'(cHalf - h), 8'h00, "gate");
        $display("test divider done");
        reg_write(8'hFE, 8'h1B);
        reg_write(8'h85, 8'h01);
        window(360);
        check(8'(near(dT, 60)), 8'h01, "crystal");
        reg_write(8'h85, 8'h00);
        window(400);
        check(8'(near(dW, 25)), 8'h01, "watchdog");
        check(8'(near(dL, 40)), 8'h01, "led");
        check(8'(near(dT, 25)), 8'h01, "timer slow");
        reg_write(8'hFE, 8'h1F);
        reg_write(8'h85, 8'h01);
        repeat (8) @(posedge mclk);
        window(360);
        check(8'(dT), 8'h00, "crystal off");
        $display("test sources done");
        reset_dut();
        final_report();
    end

    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
endmodule : scg_clock_control_test
